// ===== rtl/isao_core.sv
// Four-phase executor for increment-skip-if-nonzero and the two inclusive OR operations
`timescale 1ns/1ps

module isao_core
(
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         instr_valid,
  input  wire logic [isao_pkg::INSTR_W-1:0] instr,
  input  wire logic                         instr_two_word,
  input  wire logic                         ext_en,
  input  wire logic [isao_pkg::BANK_W-1:0]  bank_select_register,
  input  wire logic [isao_pkg::ADDR_W-1:0]  index_base,
  output logic                              instr_ready,
  output logic [1:0]                        phase,
  output logic                              skip_cycle,
  output logic                              mem_rd_en,
  output logic [isao_pkg::ADDR_W-1:0]       mem_rd_addr,
  input  wire logic [isao_pkg::DATA_W-1:0]  mem_rd_data,
  output logic                              mem_wr_en,
  output logic [isao_pkg::ADDR_W-1:0]       mem_wr_addr,
  output logic [isao_pkg::DATA_W-1:0]       mem_wr_data,
  output logic [isao_pkg::DATA_W-1:0]       accumulator,
  output logic                              flag_negative,
  output logic                              flag_zero
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    isao_pkg::isao_phase_e        q;
    isao_pkg::isao_op_e           op;
    logic                         dest_f;
    logic [isao_pkg::ADDR_W-1:0]  addr;
    logic [isao_pkg::DATA_W-1:0]  operand;
    logic [isao_pkg::DATA_W-1:0]  result;
    logic [isao_pkg::DATA_W-1:0]  acc;
    logic                         n;
    logic                         z;
    // Flags of the result, committed only by the OR operations
    logic                         rn;
    logic                         rz;
    // Skip bookkeeping
    logic                         in_skip;
    logic                         skip_pending;
  } isao_state_s;

  isao_state_s st;
  isao_state_s next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Operations that read, and may write back, a file register
  function automatic logic touches_file
  (
    input isao_pkg::isao_op_e op
  );
    return op == isao_pkg::ISAO_OP_INC_SKIP || op == isao_pkg::ISAO_OP_OR_REG;
  endfunction

  // Processing step of the third quarter-phase
  function automatic logic [isao_pkg::DATA_W-1:0] process_data
  (
    input isao_pkg::isao_op_e          op,
    input logic [isao_pkg::DATA_W-1:0] acc,
    input logic [isao_pkg::DATA_W-1:0] operand,
    input logic [isao_pkg::DATA_W-1:0] held
  );
    unique case (op)
      isao_pkg::ISAO_OP_INC_SKIP: process_data = operand + isao_pkg::ONE_B;
      isao_pkg::ISAO_OP_OR_LIT:   process_data = acc | operand;
      isao_pkg::ISAO_OP_OR_REG:   process_data = acc | operand;
      isao_pkg::ISAO_OP_NOP:      process_data = held;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  isao_dec_if dec_bus ();

  assign dec_bus.instr      = instr;
  assign dec_bus.ext_en     = ext_en;
  assign dec_bus.bank       = bank_select_register;
  assign dec_bus.index_base = index_base;

  isao_decode u_decode
  (
    .d (dec_bus.dec)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    unique case (st.q)
      isao_pkg::ISAO_Q1:
      begin
        // Decode, or discard the word already fetched
        next_st.q = isao_pkg::ISAO_Q2;
        if (st.skip_pending)
        begin
          next_st.in_skip      = 1'b1;
          next_st.op           = isao_pkg::ISAO_OP_NOP;
          // A two-word victim costs one more discarded cycle, never a third
          next_st.skip_pending = instr_valid && instr_two_word && !st.in_skip;
        end
        else
        begin
          next_st.in_skip = 1'b0;
          next_st.op      = instr_valid ? dec_bus.op : isao_pkg::ISAO_OP_NOP;
          next_st.dest_f  = dec_bus.dest_f;
          next_st.addr    = dec_bus.addr;
          next_st.operand = dec_bus.literal;
        end
      end
      isao_pkg::ISAO_Q2:
      begin
        // Operand read
        next_st.q = isao_pkg::ISAO_Q3;
        if (touches_file(st.op))
          next_st.operand = mem_rd_data;
      end
      isao_pkg::ISAO_Q3:
      begin
        // Processing
        next_st.q = isao_pkg::ISAO_Q4;
        next_st.result = process_data(st.op, st.acc, st.operand, st.result);
        {next_st.rn, next_st.rz} = isao_pkg::isao_nz(next_st.result);
      end
      isao_pkg::ISAO_Q4:
      begin
        // Destination write
        next_st.q = isao_pkg::ISAO_Q1;
        unique case (st.op)
          isao_pkg::ISAO_OP_INC_SKIP:
          begin
            // Flags stay; a nonzero result arms the skip and, with dest_f clear, the accumulator takes the result
            if (!st.dest_f)
              next_st.acc = st.result;
            next_st.skip_pending = !st.rz;
          end
          isao_pkg::ISAO_OP_OR_LIT:
          begin
            next_st.acc = st.result;
            {next_st.n, next_st.z} = {st.rn, st.rz};
          end
          isao_pkg::ISAO_OP_OR_REG:
          begin
            if (!st.dest_f)
              next_st.acc = st.result;
            {next_st.n, next_st.z} = {st.rn, st.rz};
          end
          isao_pkg::ISAO_OP_NOP:
          begin
            next_st.acc = st.acc;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st.q            <= isao_pkg::ISAO_Q1;
      st.op           <= isao_pkg::ISAO_OP_NOP;
      st.dest_f       <= 1'b0;
      st.addr         <= isao_pkg::ADDR_RST;
      st.operand      <= isao_pkg::ZERO_B;
      st.result       <= isao_pkg::ZERO_B;
      st.acc          <= isao_pkg::ACC_RST;
      st.n            <= 1'b0;
      st.z            <= 1'b0;
      st.rn           <= 1'b0;
      st.rz           <= 1'b0;
      st.in_skip      <= 1'b0;
      st.skip_pending <= 1'b0;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Handshake and phase
  // ----------------------------------------------------------------
  assign instr_ready   = (st.q == isao_pkg::ISAO_Q1);
  assign phase         = st.q;
  assign skip_cycle    = st.in_skip;

  // ----------------------------------------------------------------
  // Data memory port
  // ----------------------------------------------------------------
  assign mem_rd_en     = (st.q == isao_pkg::ISAO_Q2) && touches_file(st.op);
  assign mem_rd_addr   = st.addr;
  assign mem_wr_en     = (st.q == isao_pkg::ISAO_Q4) && st.dest_f && touches_file(st.op);
  assign mem_wr_addr   = st.addr;
  assign mem_wr_data   = st.result;

  // ----------------------------------------------------------------
  // Accumulator and status flags
  // ----------------------------------------------------------------
  assign accumulator   = st.acc;
  assign flag_negative = st.n;
  assign flag_zero     = st.z;

endmodule // isao_core

// ===== rtl/isao_pkg.sv
// Constants, encodings and helpers shared by the increment-skip and OR execution logic
package isao_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSTR_W = 16;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 12;
  localparam int BANK_W  = 4;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int OPC6_MSB = 15;
  localparam int OPC6_LSB = 10;
  localparam int OPC8_LSB = 8;
  localparam int D_BIT    = 9;
  localparam int A_BIT    = 8;
  localparam int F_MSB    = 7;
  localparam int SIGN_BIT = 7;

  localparam logic [5:0] OPC_INC_SKIP = 6'h12;
  localparam logic [5:0] OPC_OR_REG   = 6'h04;
  localparam logic [7:0] OPC_OR_LIT   = 8'h09;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [7:0]        INDEXED_F_MAX  = 8'h5F;
  localparam logic [7:0]        ACCESS_SPLIT   = 8'h60;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0]        ADDR_PAD       = 4'h0;

  // ----------------------------------------------------------------
  // Reset values and the increment constant
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;
  localparam logic [DATA_W-1:0] ONE_B    = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ISAO_Q1 = 2'b00,
    ISAO_Q2 = 2'b01,
    ISAO_Q3 = 2'b11,
    ISAO_Q4 = 2'b10
  } isao_phase_e;

  typedef enum logic [1:0] {
    ISAO_OP_NOP      = 2'b00,
    ISAO_OP_INC_SKIP = 2'b01,
    ISAO_OP_OR_LIT   = 2'b10,
    ISAO_OP_OR_REG   = 2'b11
  } isao_op_e;

  // Negative and zero of a result, {n, z}
  function automatic logic [1:0] isao_nz(input logic [DATA_W-1:0] v);
    return {v[SIGN_BIT], v == ZERO_B};
  endfunction

endpackage

// ===== rtl/isao_dec_if.sv
// Carrier between the executing core and its instruction decoder
`timescale 1ns/1ps
interface isao_dec_if;
  logic [isao_pkg::INSTR_W-1:0] instr;
  logic                         ext_en;
  logic [isao_pkg::BANK_W-1:0]  bank;
  logic [isao_pkg::ADDR_W-1:0]  index_base;
  isao_pkg::isao_op_e           op;
  logic                         dest_f;
  logic [isao_pkg::ADDR_W-1:0]  addr;
  logic [isao_pkg::DATA_W-1:0]  literal;

  modport dec  (input instr, ext_en, bank, index_base, output op, dest_f, addr, literal);
  modport core (output instr, ext_en, bank, index_base, input op, dest_f, addr, literal);
endinterface

// ===== rtl/isao_decode.sv
// Opcode decoder and data address former
`timescale 1ns/1ps
module isao_decode
(
  isao_dec_if.dec d
);

  logic [7:0] f;

  always_comb
  begin
    f         = d.instr[isao_pkg::F_MSB:0];
    d.literal = f;
    d.dest_f  = d.instr[isao_pkg::D_BIT];
    d.op      = isao_pkg::ISAO_OP_NOP;
    if (d.instr[isao_pkg::OPC6_MSB:isao_pkg::OPC6_LSB] == isao_pkg::OPC_INC_SKIP)
      d.op = isao_pkg::ISAO_OP_INC_SKIP;
    else if (d.instr[isao_pkg::OPC6_MSB:isao_pkg::OPC6_LSB] == isao_pkg::OPC_OR_REG)
      d.op = isao_pkg::ISAO_OP_OR_REG;
    else if (d.instr[isao_pkg::OPC6_MSB:isao_pkg::OPC8_LSB] == isao_pkg::OPC_OR_LIT)
      d.op = isao_pkg::ISAO_OP_OR_LIT;
    if (d.instr[isao_pkg::A_BIT])
      d.addr = {d.bank, f};
    else if (d.ext_en && f <= isao_pkg::INDEXED_F_MAX)
      d.addr = d.index_base + {isao_pkg::ADDR_PAD, f};
    else if (f < isao_pkg::ACCESS_SPLIT)
      d.addr = {isao_pkg::ACCESS_LO_BANK, f};
    else
      d.addr = {isao_pkg::ACCESS_HI_BANK, f};
  end

endmodule // isao_decode

// ===== sim/isao_core_checker.sv
// Port assertions for the four-phase executor
`timescale 1ns/1ps
module isao_core_checker
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic        instr_ready,
  input wire logic [1:0]  phase,
  input wire logic        skip_cycle,
  input wire logic        mem_rd_en,
  input wire logic        mem_wr_en,
  input wire logic [7:0]  accumulator,
  input wire logic        flag_negative,
  input wire logic        flag_zero
);
  wire logic [5:0] op6 = instr[15:10];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_phase_walk: assert property (!srst && phase == 2'b00 |=>
    phase == 2'b01 ##1 phase == 2'b11 ##1 phase == 2'b10) else $error("phase walk broken");
  chk_ready_q1: assert property (instr_ready == (phase == 2'b00))
    else $error("ready outside first phase");
  chk_read_cause: assert property (mem_rd_en |-> phase == 2'b01 && $past(instr_valid) &&
    ($past(op6) == isao_pkg::OPC_OR_REG || $past(op6) == isao_pkg::OPC_INC_SKIP)) else $error("stray read");
  chk_write_dest: assert property (mem_wr_en |-> phase == 2'b10 && $past(instr[9], 3))
    else $error("write without destination bit");
  chk_skip_quiet: assert property (skip_cycle |-> !mem_rd_en && !mem_wr_en)
    else $error("access during skip");
  chk_skip_start: assert property ($rose(skip_cycle) |-> phase == 2'b01)
    else $error("skip rose off second phase");
  chk_acc_update: assert property ($changed(accumulator) |-> phase == 2'b00)
    else $error("accumulator moved mid cycle");
  chk_flags_or: assert property ($changed({flag_negative, flag_zero}) |-> phase == 2'b00 &&
    ($past(op6, 4) == isao_pkg::OPC_OR_REG || $past(instr[15:8], 4) == isao_pkg::OPC_OR_LIT))
    else $error("flags moved without an OR");
  cov_skip: cover property ($rose(skip_cycle));
  cov_write: cover property (mem_wr_en);
  cov_zero: cover property ($rose(flag_zero));
endmodule // isao_core_checker
bind isao_core isao_core_checker u_chk (.*);

// ===== sim/isao_core_tb.sv
// Self-checking bench for the increment-skip and OR executor
`timescale 1ns/1ps
module isao_core_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        instr_two_word = 1'b0;
  logic        ext_en = 1'b0;
  logic [3:0]  bank_select_register = 4'h0;
  logic [11:0] index_base = 12'h000;
  logic [7:0]  mem_rd_data = 8'h00;
  logic        instr_ready, skip_cycle, mem_rd_en, mem_wr_en, flag_negative, flag_zero;
  logic [1:0]  phase;
  logic [11:0] mem_rd_addr, mem_wr_addr, ra, wa;
  logic [7:0]  mem_wr_data, accumulator, wd;
  int          err_count = 0, n_tests = 0, rdn, wrn, skn;

  always #25 clk = ~clk;
  isao_core u_dut (.*);

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check("reset", {phase, instr_ready, accumulator, flag_negative, flag_zero}, {3'b001, 10'h000});
    check("reset strobes", {mem_rd_en, mem_wr_en, skip_cycle}, 3'b000);
    @(posedge clk);
    srst <= 1'b0;
  endtask

  // Returns at the edge that starts a first phase
  task automatic align;
    do @(posedge clk); while (phase !== 2'b10);
  endtask

  // One instruction cycle; records reads, writes and skip phases
  task automatic feed(input logic [15:0] w, input logic tw, input logic [7:0] rd);
    instr <= w;
    instr_valid <= 1'b1;
    instr_two_word <= tw;
    mem_rd_data <= rd;
    @(posedge clk);
    instr_valid <= 1'b0;
    rdn = 0;
    wrn = 0;
    skn = 0;
    repeat (3)
    begin
      @(posedge clk);
      rdn += (mem_rd_en === 1'b1);
      wrn += (mem_wr_en === 1'b1);
      skn += (skip_cycle === 1'b1);
      if (mem_rd_en === 1'b1) ra = mem_rd_addr;
      if (mem_wr_en === 1'b1) {wa, wd} = {mem_wr_addr, mem_wr_data};
    end
  endtask

  task automatic t_or_lit;
    align;
    feed(16'h0900, 1'b0, 8'h00);
    #1 check("lit zero", {accumulator, flag_negative, flag_zero}, {8'h00, 2'b01});
    align;
    feed(16'h099A, 1'b0, 8'h00);
    feed(16'h0935, 1'b0, 8'h00);
    check("lit bus", {rdn[3:0], wrn[3:0]}, 8'h00);
    #1 check("lit acc", {accumulator, flag_negative, flag_zero}, {8'hBF, 2'b10});
    $display("t_or_lit done");
  endtask

  task automatic t_or_reg;
    logic [15:0] w[5] = '{16'h1010, 16'h1060, 16'h1125, 16'h105F, 16'h1060};
    logic [11:0] a[5] = '{12'h010, 12'hF60, 12'h325, 12'h15F, 12'hF60};
    logic [7:0]  d[5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80};
    logic [7:0]  acc = 8'h00;
    do_reset;
    align;
    feed(16'h1230, 1'b0, 8'h00);
    check("or write", {wrn[3:0], wa, wd}, {4'h1, 12'h030, 8'h00});
    #1 check("or flags", {accumulator, flag_negative, flag_zero}, {8'h00, 2'b01});
    for (int i = 0; i < 5; i++)
    begin
      align;
      ext_en <= (i > 2);
      bank_select_register <= 4'h3;
      index_base <= 12'h100;
      acc |= d[i];
      feed(w[i], 1'b0, d[i]);
      check("or read", {wrn[3:0], rdn[3:0], ra}, {8'h01, a[i]});
      #1 check("or acc", {accumulator, flag_negative}, {acc, acc[7]});
    end
    $display("t_or_reg done");
  endtask

  task automatic t_inc_zero;
    align;
    feed(16'h4A10, 1'b0, 8'hFF);
    check("inc write", {wrn[3:0], wa, wd}, {4'h1, 12'h110, 8'h00});
    feed(16'h0910, 1'b0, 8'h00);
    #1 check("no skip", {skn[3:0], accumulator, flag_negative}, {4'h0, 8'h9F, 1'b1});
    $display("t_inc_zero done");
  endtask

  task automatic t_inc_skip;
    align;
    feed(16'h4810, 1'b0, 8'h41);
    check("inc read", {wrn[3:0], rdn[3:0], ra}, {8'h01, 12'h110});
    feed(16'h0920, 1'b0, 8'h00);
    check("skip idle", {skn[3:0], rdn[3:0], wrn[3:0]}, 12'h300);
    #1 check("skip acc", {accumulator, flag_negative, flag_zero}, {8'h42, 2'b10});
    $display("t_inc_skip done");
  endtask

  task automatic t_inc_skip2;
    align;
    feed(16'h4A20, 1'b0, 8'h7F);
    check("inc dest", {wrn[3:0], wa, wd}, {4'h1, 12'h120, 8'h80});
    feed(16'h0901, 1'b1, 8'h00);
    feed(16'h1230, 1'b0, 8'h00);
    check("second skip", {skn[3:0], rdn[3:0], wrn[3:0]}, 12'h300);
    feed(16'h0904, 1'b0, 8'h00);
    #1 check("after skip", {accumulator, flag_negative, flag_zero}, {8'h46, 2'b00});
    $display("t_inc_skip2 done");
  endtask

  initial
  begin
    do_reset;
    t_or_lit;
    t_or_reg;
    t_inc_zero;
    t_inc_skip;
    t_inc_skip2;
    report_and_stop;
  end

  initial
  begin
    repeat (2000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
endmodule // isao_core_tb
